// ==== pkg/pll_strap_pkg.sv ====
// Contract
// R01: clock-off codes stop all internal clocking
// R02: board applies only defined strap codes
// R03: strap readable in bits 7-4 at 0xE2; the code puts all five bits in 7-3, the last one in bit 3
// R04: single bypass: pci clock drives processor directly
// R05: dual bypass: pci clock drives peripheral, 1:1
// R06: dual bypass: oscillator drives processor, 1:1
// R07: board keeps both bypass clocks synchronised
// R08: top grade codes 0-4 map fixed multipliers
// R09: lower grades: 1E, 1F turn multipliers off
// R10: strap sampled in reset, held until next
package pll_strap_pkg;

	// register indices; byte address is four times the index
	localparam logic [9:0] REG_IDX_CTRL   = 10'h0E0;
	localparam logic [9:0] REG_IDX_STATUS = 10'h0E1;
	localparam logic [9:0] REG_IDX_STRAP  = 10'h0E2;

	// field positions
	localparam int CTRL_STOP_BIT  = 0;
	localparam int STRAP_FLD_LSB  = 3;
	localparam int STAT_MODE_LSB  = 0;
	localparam int STAT_RSV_BIT   = 3;
	localparam int STAT_MEM_LSB   = 4;
	localparam int STAT_CPU_LSB   = 8;

	// reset values and the bypass 1:1 ratio
	localparam logic       CTRL_STOP_RST = 1'h0;
	localparam logic [3:0] MULT_X2_OFF   = 4'h0;
	localparam logic [3:0] MULT_X2_ONE   = 4'h2;

	// strap codes with a fixed meaning
	localparam logic [4:0] CODE_OFF_A      = 5'h1E;
	localparam logic [4:0] CODE_OFF_B      = 5'h1F;
	localparam logic [4:0] CODE_SINGLE_BYP = 5'h06;
	localparam logic [4:0] CODE_DUAL_BYP   = 5'h05;
	localparam logic [4:0] CODE_TOP_LAST   = 5'h04;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_SINGLE = 3'b001,
		MODE_DUAL   = 3'b010,
		MODE_OFF    = 3'b011,
		MODE_RSV    = 3'b100
	} mode_t;

	typedef enum logic [1:0] {
		SRC_PLL = 2'b00,
		SRC_PCI = 2'b01,
		SRC_OSC = 2'b10,
		SRC_OFF = 2'b11
	} clk_src_t;

	// top-grade table: {valid, mem pll bypassed, pci-to-mem x2, mem-to-cpu x2}
	function automatic logic [9:0] rate_top(input logic [4:0] code);
		logic [9:0] r;
		r = 10'h000;
		case (code)
			5'h00: r = {1'b1, 1'b0, 4'h6, 4'h5};
			5'h01: r = {1'b1, 1'b0, 4'h6, 4'h6};
			5'h02: r = {1'b1, 1'b0, 4'h2, 4'h9};
			5'h03: r = {1'b1, 1'b1, 4'h2, 4'h4};
			5'h04: r = {1'b1, 1'b0, 4'h4, 4'h4};
			default: r = 10'h000;
		endcase
		return r;
	endfunction : rate_top

endpackage : pll_strap_pkg

// ==== pkg/clk_plan_if.sv ====
// decoded clock arrangement passed from the decoder to the top
interface clk_plan_if;
	import pll_strap_pkg::*;
	mode_t      mode;
	clk_src_t   proc_src;
	clk_src_t   periph_src;
	logic       mem_pll_en;
	logic       cpu_pll_en;
	logic [3:0] mem_x2;
	logic [3:0] cpu_x2;

	modport producer (output mode, proc_src, periph_src, mem_pll_en, cpu_pll_en,
		mem_x2, cpu_x2);
	modport consumer (input mode, proc_src, periph_src, mem_pll_en, cpu_pll_en,
		mem_x2, cpu_x2);
endinterface : clk_plan_if

// ==== core/strap_decode.sv ====
module strap_decode
	import pll_strap_pkg::*;
(
	input  wire logic [4:0] strap_i,  // latched strap
	input  wire logic       top_grade_i, // high for the fastest grade
	clk_plan_if.producer    plan      // decoded arrangement
);

	logic [9:0] top_w;
	assign top_w = rate_top(strap_i);

	// unlisted codes fall to reserved with every clock held off, the safe answer
	always_comb begin
		plan.mode       = MODE_RSV;
		plan.proc_src   = SRC_OFF;
		plan.periph_src = SRC_OFF;
		plan.mem_pll_en = 1'b0;
		plan.cpu_pll_en = 1'b0;
		plan.mem_x2     = MULT_X2_OFF;
		plan.cpu_x2     = MULT_X2_OFF;
		unique case (strap_i)
			CODE_OFF_A, CODE_OFF_B: begin
				plan.mode = MODE_OFF; // see R01 see R09
			end
			CODE_SINGLE_BYP: begin
				plan.mode       = MODE_SINGLE;
				plan.proc_src   = SRC_PCI; // see R04
				plan.periph_src = SRC_PCI;
				plan.mem_x2     = MULT_X2_ONE; // see R04
				plan.cpu_x2     = MULT_X2_ONE;
			end
			CODE_DUAL_BYP: begin
				plan.mode       = MODE_DUAL;
				plan.periph_src = SRC_PCI; // see R05
				plan.proc_src   = SRC_OSC; // see R06
				plan.mem_x2     = MULT_X2_ONE;
				plan.cpu_x2     = MULT_X2_ONE;
			end
			default: begin
				if (top_grade_i && top_w[9]) begin
					plan.mode       = MODE_NORMAL; // see R08
					plan.proc_src   = SRC_PLL;
					plan.periph_src = top_w[8] ? SRC_PCI : SRC_PLL;
					plan.mem_pll_en = !top_w[8];
					plan.cpu_pll_en = 1'b1;
					plan.mem_x2     = top_w[7:4];
					plan.cpu_x2     = top_w[3:0];
				end
			end
		endcase
	end

endmodule : strap_decode

// ==== core/pll_config_strap_decoder.sv ====
module pll_config_strap_decoder
	import pll_strap_pkg::*;
(
	input  wire logic        clk_i,          // 250 MHz system clock
	input  wire logic        rst_i,          // synchronous reset, high
	input  wire logic [4:0]  strap_i,        // board strap, msb first
	input  wire logic        top_grade_i,    // speed grade strap
	input  wire logic        wb_cyc_i,       // wishbone cycle
	input  wire logic        wb_stb_i,       // wishbone strobe
	input  wire logic        wb_we_i,        // wishbone write
	input  wire logic [11:0] wb_adr_i,       // byte address
	input  wire logic [3:0]  wb_sel_i,       // byte lanes
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	output logic             wb_ack_o,       // acknowledge
	output logic      [1:0]  proc_src_o,     // processor clock source
	output logic      [1:0]  periph_src_o,   // peripheral clock source
	output logic             mem_pll_en_o,   // peripheral pll enable
	output logic             cpu_pll_en_o,   // processor pll enable
	output logic      [3:0]  mem_mult_x2_o,  // pci-to-mem ratio times two
	output logic      [3:0]  cpu_mult_x2_o,  // mem-to-cpu ratio times two
	output logic             clk_run_o,      // internal clocks may run
	output logic             strap_rsv_o     // strap code has no meaning
);

	// latched straps
	logic [4:0] strap_r;
	logic       grade_r;

	// control and bus state
	logic       stop_r;
	logic       ack_r;
	logic [31:0] dat_r;

	// output flops
	clk_src_t   proc_src_r;
	clk_src_t   periph_src_r;
	logic       mem_pll_en_r;
	logic       cpu_pll_en_r;
	logic [3:0] mem_x2_r;
	logic [3:0] cpu_x2_r;
	logic       run_r;
	logic       rsv_r;

	// decoder
	clk_plan_if plan ();

	strap_decode u_decode (
		.strap_i     (strap_r),
		.top_grade_i (grade_r),
		.plan        (plan)
	);

	// straps are caught only while reset is held, so the arrangement
	// cannot shift under running logic if the board drifts later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_r <= strap_i; // see R10
			grade_r <= top_grade_i; // see R10
		end
	end

	// bus decode
	logic [9:0] idx_w;
	logic       req_w;
	logic       rd_cyc_w;
	logic       wr_w;
	logic       hit_ctrl_w;
	logic       hit_stat_w;
	logic       hit_strap_w;
	logic [31:0] rd_mux_w;
	logic [31:0] stat_w;
	logic [31:0] strap_rb_w;
	logic        stop_nxt;

	assign idx_w       = wb_adr_i[11:2];
	assign req_w       = wb_cyc_i && wb_stb_i;
	assign rd_cyc_w    = req_w && !ack_r;
	assign wr_w        = req_w && wb_we_i && ack_r;
	assign hit_ctrl_w  = (idx_w == REG_IDX_CTRL);
	assign hit_stat_w  = (idx_w == REG_IDX_STATUS);
	assign hit_strap_w = (idx_w == REG_IDX_STRAP);

	// status view of the ratio and reserved flops as they stand, with the decoded mode in bits 2-0
	assign stat_w = {20'h0_0000,
		cpu_x2_r,
		mem_x2_r,
		rsv_r,
		plan.mode};

	// strap readback, upper four code bits in 7-4, the last one in bit 3
	assign strap_rb_w = {24'h00_0000, strap_r, 3'h0}; // see R03

	// unmapped words read as zero and swallow writes
	assign rd_mux_w = hit_ctrl_w  ? {31'h0000_0000, stop_r} :
	                  hit_stat_w  ? stat_w :
	                  hit_strap_w ? strap_rb_w :
	                  32'h0000_0000;

	// the readback register has no write path; only the stop bit takes writes
	assign stop_nxt = (wr_w && hit_ctrl_w && wb_sel_i[0]) ?
		wb_dat_i[CTRL_STOP_BIT] : stop_r;

	// ack one cycle after the request; write lands on the acked edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= rd_cyc_w;
		end
	end

	// read data captured with the ack and held through it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (rd_cyc_w) begin
			dat_r <= rd_mux_w;
		end
	end

	// soft stop bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_r <= CTRL_STOP_RST;
		end else begin
			stop_r <= stop_nxt;
		end
	end

	// next values for the clock controls
	logic     run_nxt;
	logic     off_w;
	clk_src_t proc_nxt;
	clk_src_t periph_nxt;

	// off and reserved modes and the soft stop all override the decoded clock sources entirely
	assign off_w      = (plan.mode == MODE_OFF) || (plan.mode == MODE_RSV);
	assign run_nxt    = !off_w && !stop_r; // see R01
	assign proc_nxt   = run_nxt ? plan.proc_src : SRC_OFF; // see R01
	assign periph_nxt = run_nxt ? plan.periph_src : SRC_OFF;

	// registered clock controls; reset parks every clock off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			proc_src_r   <= SRC_OFF;
			periph_src_r <= SRC_OFF;
			mem_pll_en_r <= 1'b0;
			cpu_pll_en_r <= 1'b0;
			run_r        <= 1'b0;
		end else begin
			proc_src_r   <= proc_nxt;
			periph_src_r <= periph_nxt;
			mem_pll_en_r <= plan.mem_pll_en && run_nxt; // see R04 see R05
			cpu_pll_en_r <= plan.cpu_pll_en && run_nxt; // see R06
			run_r        <= run_nxt;
		end
	end

	// registered ratios and reserved flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_x2_r <= MULT_X2_OFF;
			cpu_x2_r <= MULT_X2_OFF;
			rsv_r    <= 1'b0;
		end else begin
			mem_x2_r <= plan.mem_x2; // see R08 see R09
			cpu_x2_r <= plan.cpu_x2; // see R08 see R09
			rsv_r    <= (plan.mode == MODE_RSV);
		end
	end

	// ports straight from flops
	assign wb_ack_o      = ack_r;
	assign wb_dat_o      = dat_r;
	assign proc_src_o    = proc_src_r;
	assign periph_src_o  = periph_src_r;
	assign mem_pll_en_o  = mem_pll_en_r;
	assign cpu_pll_en_o  = cpu_pll_en_r;
	assign mem_mult_x2_o = mem_x2_r;
	assign cpu_mult_x2_o = cpu_x2_r;
	assign clk_run_o     = run_r;
	assign strap_rsv_o   = rsv_r;

	// helper: table entry for the latched code
	logic [9:0] top_ref_w;
	assign top_ref_w = rate_top(strap_r);

	property p_r01;
		@(posedge clk_i) disable iff (rst_i)
		(strap_r == CODE_OFF_A || strap_r == CODE_OFF_B)
			|=> !clk_run_o && proc_src_o == SRC_OFF && periph_src_o == SRC_OFF
			&& !mem_pll_en_o && !cpu_pll_en_o;
	endproperty
	a_r01: assert property (p_r01) // see R01
		else $error("clock-off code left a clock running");

	property p_r03;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && $past(wb_cyc_i && wb_stb_i && !wb_we_i && hit_strap_w)
			|-> wb_dat_o[7:4] == strap_r[4:1] && wb_dat_o[3] == strap_r[0]
			&& wb_dat_o[31:8] == 24'h00_0000;
	endproperty
	a_r03: assert property (p_r03) // see R03
		else $error("strap readback does not match latched strap");

	property p_r04;
		@(posedge clk_i) disable iff (rst_i)
		(strap_r == CODE_SINGLE_BYP && !stop_r)
			|=> proc_src_o == SRC_PCI && !mem_pll_en_o && mem_mult_x2_o == MULT_X2_ONE;
	endproperty
	a_r04: assert property (p_r04) // see R04
		else $error("single bypass not applied");

	property p_r05;
		@(posedge clk_i) disable iff (rst_i)
		(strap_r == CODE_DUAL_BYP && !stop_r)
			|=> periph_src_o == SRC_PCI && !mem_pll_en_o
			&& mem_mult_x2_o == MULT_X2_ONE;
	endproperty
	a_r05: assert property (p_r05) // see R05
		else $error("dual bypass peripheral clock wrong");

	property p_r06;
		@(posedge clk_i) disable iff (rst_i)
		(strap_r == CODE_DUAL_BYP && !stop_r)
			|=> proc_src_o == SRC_OSC && !cpu_pll_en_o && cpu_mult_x2_o == MULT_X2_ONE;
	endproperty
	a_r06: assert property (p_r06) // see R06
		else $error("dual bypass processor clock wrong");

	property p_r08;
		@(posedge clk_i) disable iff (rst_i)
		(grade_r && strap_r <= CODE_TOP_LAST) ##1 !rst_i
			|-> mem_mult_x2_o == $past(top_ref_w[7:4])
			&& cpu_mult_x2_o == $past(top_ref_w[3:0])
			&& strap_rsv_o == 1'b0;
	endproperty
	a_r08: assert property (p_r08) // see R08
		else $error("top grade multiplier mismatch");

	property p_r09;
		@(posedge clk_i) disable iff (rst_i)
		(!grade_r && strap_r[4:1] == CODE_OFF_A[4:1])
			|=> mem_mult_x2_o == MULT_X2_OFF && cpu_mult_x2_o == MULT_X2_OFF
			&& !clk_run_o;
	endproperty
	a_r09: assert property (p_r09) // see R09
		else $error("lower grade off code left a multiplier on");

	property p_r10;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) && !$past(rst_i, 2) |-> $stable(strap_r) && $stable(grade_r)
			&& $stable(mem_mult_x2_o) && $stable(cpu_mult_x2_o);
	endproperty
	a_r10: assert property (p_r10) // see R10
		else $error("strap or decoded ratio changed outside reset");

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack held longer than one cycle");

	// an ack only ever answers a request taken on the edge before
	property p_ack_req;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
	endproperty
	a_ack_req: assert property (p_ack_req)
		else $error("ack without a pending request");

	// soft stop parks every clock one edge after it is seen
	property p_stop;
		@(posedge clk_i) disable iff (rst_i)
		stop_r |=> !clk_run_o && proc_src_o == SRC_OFF && periph_src_o == SRC_OFF
			&& !mem_pll_en_o && !cpu_pll_en_o;
	endproperty
	a_stop: assert property (p_stop)
		else $error("soft stop left a clock running");

	// a running block always has a real source on both clock trees
	property p_run;
		@(posedge clk_i) disable iff (rst_i)
		clk_run_o |-> proc_src_o != SRC_OFF && periph_src_o != SRC_OFF && !strap_rsv_o;
	endproperty
	a_run: assert property (p_run) // see R01
		else $error("running with a clock tree parked");

	// reserved codes keep the ratios off as well as the clocks
	property p_rsv;
		@(posedge clk_i) disable iff (rst_i)
		strap_rsv_o |-> !clk_run_o && mem_mult_x2_o == MULT_X2_OFF
			&& cpu_mult_x2_o == MULT_X2_OFF;
	endproperty
	a_rsv: assert property (p_rsv)
		else $error("reserved code left a ratio or clock on");

	// clock-off codes show zero ratios in every grade
	property p_off_ratio;
		@(posedge clk_i) disable iff (rst_i)
		(strap_r == CODE_OFF_A || strap_r == CODE_OFF_B)
			|=> mem_mult_x2_o == MULT_X2_OFF && cpu_mult_x2_o == MULT_X2_OFF;
	endproperty
	a_off_ratio: assert property (p_off_ratio) // see R01
		else $error("clock-off code shows a ratio");

	// status read returns the ratio and reserved flops as they stand
	property p_stat_rd;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && $past(req_w && !wb_we_i && hit_stat_w)
			|-> wb_dat_o[11:8] == cpu_mult_x2_o && wb_dat_o[7:4] == mem_mult_x2_o
			&& wb_dat_o[3] == strap_rsv_o && wb_dat_o[31:12] == 20'h0_0000;
	endproperty
	a_stat_rd: assert property (p_stat_rd) // see R08
		else $error("status read does not match the ratio outputs");

endmodule : pll_config_strap_decoder

// ==== dv/strap_board.sv ====
// board strapping and external clock sources seen by the decoder
module strap_board (
	input  wire logic       clk_i,                    // bench clock
	input  wire logic [4:0] code_i,                   // code the bench wants fitted
	input  wire logic       grade_i,                  // speed grade fitted
	output logic      [4:0] strap_o,                  // strap pins
	output logic            top_grade_o,              // grade strap pin
	output logic            pci_sync_clk_o,           // pci synchronisation clock
	output logic            oscillator_clock_input_o  // oscillator clock
);
	timeunit 1ns;
	timeprecision 1ps;

	// both sources come from one edge so bypass modes see them aligned
	assign pci_sync_clk_o           = clk_i;
	assign oscillator_clock_input_o = clk_i;

	// straps settle a cycle after the bench asks; reserved codes only on purpose
	always_ff @(posedge clk_i) begin
		strap_o     <= code_i;
		top_grade_o <= grade_i;
	end
endmodule : strap_board

// ==== dv/testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

	localparam logic [7:0] TOP_X2 [5] = '{8'h65, 8'h66, 8'h29, 8'h24, 8'h44};
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic [4:0]  code_r   = 5'h00;
	logic        grade_r  = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [4:0]  strap;
	logic        top_grade;
	logic [1:0]  proc_src_o, periph_src_o;
	logic        mem_pll_en_o, cpu_pll_en_o, clk_run_o, strap_rsv_o;
	logic [3:0]  mem_mult_x2_o, cpu_mult_x2_o;
	int          miscompares = 0;
	int          check_count = 0;
	int          seed        = 19;
	logic [15:0] outs;
	assign outs = {proc_src_o, periph_src_o, mem_pll_en_o, cpu_pll_en_o, mem_mult_x2_o,
		cpu_mult_x2_o, clk_run_o, strap_rsv_o};

	always #2 clk_i = ~clk_i;

	strap_board board (.clk_i(clk_i), .code_i(code_r), .grade_i(grade_r), .strap_o(strap),
		.top_grade_o(top_grade), .pci_sync_clk_o(), .oscillator_clock_input_o());
	pll_config_strap_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .strap_i(strap),
		.top_grade_i(top_grade), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .proc_src_o(proc_src_o), .periph_src_o(periph_src_o),
		.mem_pll_en_o(mem_pll_en_o), .cpu_pll_en_o(cpu_pll_en_o), .mem_mult_x2_o(mem_mult_x2_o),
		.cpu_mult_x2_o(cpu_mult_x2_o), .clk_run_o(clk_run_o), .strap_rsv_o(strap_rsv_o));

	// {mode, proc src, periph src, mem en, cpu en, mem x2, cpu x2, run, reserved}
	function automatic logic [18:0] exp_of(input logic [4:0] c, input logic g);
		logic [18:0] e;
		e = {3'h4, 2'h3, 2'h3, 2'h0, 8'h00, 2'h1};
		if (c >= 5'h1E) e = {3'h3, 2'h3, 2'h3, 2'h0, 8'h00, 2'h0};
		else if (c == 5'h06) e = {3'h1, 2'h1, 2'h1, 2'h0, 8'h22, 2'h2};
		else if (c == 5'h05) e = {3'h2, 2'h2, 2'h1, 2'h0, 8'h22, 2'h2};
		else if (g && c <= 5'h04) begin
			e = {3'h0, 2'h0, 2'h0, 2'h3, TOP_X2[c], 2'h2};
			if (c == 5'h03) e[13:11] = 3'h2; // memory pll bypassed
		end
		return e;
	endfunction : exp_of

	// classic single cycle; signals move only just after an edge
	task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			results();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	// strap during reset, then move the pins to prove they are ignored
	task automatic run_code(input logic [4:0] c, input logic g);
		logic [18:0] e;
		logic [31:0] q;
		e = exp_of(c, g);
		rst_i   <= 1'b1;
		code_r  <= c;
		grade_r <= g;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		code_r  <= 5'($random(seed));
		grade_r <= ~g;
		repeat (3) @(posedge clk_i);
		`CHK("clock plan", e[15:0], outs)
		wb(1'b0, 12'h384, 4'hf, 32'h0000_0000, q);
		`CHK("status", {20'h0_0000, e[5:2], e[9:6], e[0], e[18:16]}, q)
		wb(1'b0, 12'h388, 4'hf, 32'h0000_0000, q);
		`CHK("readback", {24'h00_0000, c, 3'h0}, q)
	endtask : run_code

	task automatic results();
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// every code in both grades, then random codes and grades
	initial begin
		logic [31:0] q;
		logic [18:0] e;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i < 80; i++) begin
			run_code((i < 64) ? i[4:0] : 5'($random(seed)), (i < 64) ? i[5] : 1'($random(seed)));
		end
		run_code(5'h03, 1'b1);
		wb(1'b1, 12'h380, 4'he, 32'h0000_0001, q); // lane 0 off: stop bit untouched
		wb(1'b1, 12'h388, 4'hf, 32'hffff_ffff, q);
		wb(1'b0, 12'h388, 4'hf, 32'h0000_0000, q);
		`CHK("ro readback", {24'h00_0000, 5'h03, 3'h0}, q)
		wb(1'b0, 12'h38c, 4'hf, 32'h0000_0000, q);
		`CHK("unmapped", 32'h0000_0000, q)
		`CHK("held plan", exp_of(5'h03, 1'b1) & 19'h0_ffff, {3'h0, outs})
		// soft stop through lane 0: every source parked, ratios kept
		e = exp_of(5'h03, 1'b1);
		wb(1'b1, 12'h380, 4'h1, 32'h0000_0001, q);
		@(posedge clk_i);
		`CHK("stopped plan", {6'h3c, e[9:2], 2'h0}, outs)
		wb(1'b0, 12'h380, 4'hf, 32'h0000_0000, q);
		`CHK("stop bit", 32'h0000_0001, q)
		wb(1'b1, 12'h380, 4'h1, 32'h0000_0000, q);
		@(posedge clk_i);
		`CHK("resumed plan", e[15:0], outs)
		results();
	end
endmodule : testbench
